// *** include/sector_clear_defs.vh ***
// Constants for the sector clear engine: geometry, timing and error codes.
// Assumes a single 100 MHz clock and inclusion by bare name.
//
// Function
// - Clear requested sectors to FFFF in RAM, flash.
// - Sixteen sectors of 2048 words each.
// - Count operand means whole consecutive sectors.
// - With cassette each sector takes 18 ms.
// - Without cassette RAM only, 1 ms each.
// - Track longest scan time in 0.1 ms units.
// - Bad head or overflow gives error 6706.
// - Write protect with cassette refuses clear, error 6770.
// - Each clear with cassette is one flash write cycle.
`ifndef SECTOR_CLEAR_DEFS_VH
`define SECTOR_CLEAR_DEFS_VH

`define ERASED_WORD     16'hFFFF
`define SECTOR_WORDS    16'h0800
`define SECTOR_SHIFT    11
`define SECTOR_LOW_MASK 15'h07FF
`define LAST_WORD       15'h7FFF
`define WORD_AW         15
`define ERR_RANGE       16'h1A32
`define ERR_PROTECT     16'h1A72
`define CLK_MHZ         100
`define FLASH_SECTOR_MS 18
`define RAM_SECTOR_MS   1
`define SCAN_UNIT_US    100
`define WDT_FREE_MS     200
`define WRITE_LIMIT     10000

`endif

// *** src/sector_clear.v ***
// Sector clear engine: fills sectors of RAM and, with a cassette, flash.
// Assumes command inputs and scan markers come from logic on mclk; the
// cassette presence and protect switch are pins and are synchronised.
`timescale 1ns/100ps
`default_nettype none
`include "sector_clear_defs.vh"
module sector_clear #(
   parameter FLASH_SECTOR_CYC = `FLASH_SECTOR_MS * 1000 * `CLK_MHZ,
   parameter RAM_SECTOR_CYC   = `RAM_SECTOR_MS * 1000 * `CLK_MHZ,
   parameter SCAN_TICK_CYC    = `SCAN_UNIT_US * `CLK_MHZ
) (
   input  wire        mclk,
   input  wire        rst,
   input  wire        enable,
   input  wire        singleShot,
   input  wire [14:0] startWord,
   input  wire [4:0]  sectorCount,
   input  wire        cassettePresent,
   input  wire        protectSwitch,
   input  wire        scanStart,
   input  wire [14:0] ramRdAddr,
   output reg  [15:0] ramRdData,
   output reg         flashWrEn,
   output reg  [14:0] flashWrAddr,
   output reg  [15:0] flashWrData,
   output reg         busy,
   output reg         execDone,
   output reg         operationErrorFlag,
   output reg  [15:0] operationErrorCode,
   output reg  [15:0] maxScanTimeWord,
   output reg  [15:0] flashWriteCount,
   output reg         writeLimitReached
);
   // ==========================================================
   // States
   localparam IDLE = 3'b001;
   localparam FILL = 3'b010;
   localparam PACE = 3'b100;

   reg [2:0]  state_r;
   reg [1:0]  presSync_r;
   reg [1:0]  protSync_r;
   reg        enPrev_r;
   reg [14:0] addr_r;
   reg [14:0] endAddr_r;
   reg        useFlash_r;
   reg [31:0] pace_r;
   reg [31:0] paceLoad_r;
   reg        ramWrEn;
   wire [15:0] ramQ;

   // Pulse form fires once on the rising edge of enable; the continuous
   // form re-fires after every finished clear, each one made with a cassette spending a
   // flash write cycle, which is why single shot is advised.
   wire trig = enable & (singleShot ? ~enPrev_r : 1'b1);
   wire headOk = (startWord & `SECTOR_LOW_MASK) == 15'h0000;
   wire [16:0] endSum = {2'b00, startWord} +
                        {1'b0, sectorCount, 11'h000};
   wire overflow = endSum > {2'b00, `LAST_WORD} + 17'h00001;
   wire zeroCnt = sectorCount == 5'h00;

   // ==========================================================
   // Pin synchronisers
   always @(posedge mclk) begin
      if (rst) begin
         presSync_r <= 2'b00;
         protSync_r <= 2'b00;
      end else begin
         presSync_r <= {presSync_r[0], cassettePresent};
         protSync_r <= {protSync_r[0], protectSwitch};
      end
   end
   wire present = presSync_r[1];
   wire prot    = protSync_r[1];

   // ==========================================================
   // RAM store
   word_writer #(.AW(`WORD_AW), .DW(16)) ram (
      .mclk   (mclk),
      .wrEn   (ramWrEn),
      .wrAddr (addr_r),
      .wrData (`ERASED_WORD),
      .rdAddr (ramRdAddr),
      .rdData (ramQ)
   );
   always @(posedge mclk) begin
      ramRdData <= ramQ;
   end

   // ==========================================================
   // Clear sequencer
   always @* begin
      ramWrEn = (state_r == FILL);
   end

   always @(posedge mclk) begin
      if (rst) begin
         state_r <= IDLE;
         enPrev_r <= 1'b0;
         addr_r <= 15'h0000;
         endAddr_r <= 15'h0000;
         useFlash_r <= 1'b0;
         pace_r <= 32'h00000000;
         paceLoad_r <= 32'h00000000;
         flashWrEn <= 1'b0;
         flashWrAddr <= 15'h0000;
         flashWrData <= 16'h0000;
         busy <= 1'b0;
         execDone <= 1'b0;
         operationErrorFlag <= 1'b0;
         operationErrorCode <= 16'h0000;
         flashWriteCount <= 16'h0000;
         writeLimitReached <= 1'b0;
      end else begin
         enPrev_r <= enable;
         execDone <= 1'b0;
         flashWrEn <= 1'b0;
         case (state_r)
            IDLE: begin
               if (trig) begin
                  // A refused command writes nothing and is not counted
                  // as a flash write cycle, so it never wears the cassette.
                  if (present && prot) begin
                     operationErrorFlag <= 1'b1;
                     operationErrorCode <= `ERR_PROTECT;
                     execDone <= 1'b1;
                  end else if (!headOk || zeroCnt) begin
                     operationErrorFlag <= 1'b1;
                     operationErrorCode <= `ERR_RANGE;
                     execDone <= 1'b1;
                  end else begin
                     if (overflow) begin
                        operationErrorFlag <= 1'b1;
                        operationErrorCode <= `ERR_RANGE;
                        endAddr_r <= `LAST_WORD;
                     end else begin
                        endAddr_r <= endSum[14:0] - 15'h0001;
                     end
                     addr_r <= startWord;
                     useFlash_r <= present;
                     paceLoad_r <= present ? FLASH_SECTOR_CYC
                                           : RAM_SECTOR_CYC;
                     pace_r <= 32'h00000000;
                     busy <= 1'b1;
                     state_r <= FILL;
                     if (present) begin
                        flashWriteCount <= flashWriteCount + 16'h0001;
                        if (flashWriteCount + 16'h0001 >=
                            `WRITE_LIMIT) begin
                           writeLimitReached <= 1'b1;
                        end
                     end
                  end
               end
            end
            FILL: begin
               // One word per cycle; the pacing counter runs alongside
               // so each sector costs its documented time overall.
               pace_r <= pace_r + 32'h00000001;
               flashWrEn <= useFlash_r;
               flashWrAddr <= addr_r;
               flashWrData <= `ERASED_WORD;
               if ((addr_r & `SECTOR_LOW_MASK) == `SECTOR_LOW_MASK) begin
                  state_r <= PACE;
               end else begin
                  addr_r <= addr_r + 15'h0001;
               end
            end
            PACE: begin
               pace_r <= pace_r + 32'h00000001;
               if (pace_r >= paceLoad_r - 32'h00000001) begin
                  pace_r <= 32'h00000000;
                  if (addr_r == endAddr_r) begin
                     busy <= 1'b0;
                     execDone <= 1'b1;
                     state_r <= IDLE;
                  end else begin
                     addr_r <= addr_r + 15'h0001;
                     state_r <= FILL;
                  end
               end
            end
            default: begin
               state_r <= IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Longest scan time, in 0.1 ms steps, for watchdog sizing.
   // The time from reset to the first scan marker is not a scan, so
   // nothing is recorded until one marker has been seen. A step that
   // completes on the closing marker itself still counts; otherwise a
   // scan of whole steps would read one step short.
   reg [31:0]  tick_r;
   reg [15:0]  scanCur_r;
   reg         scanSeen_r;
   wire        stepDue = tick_r >= SCAN_TICK_CYC - 1;
   wire [15:0] scanFinal = (stepDue && scanCur_r != 16'hFFFF) ?
                           scanCur_r + 16'h0001 : scanCur_r;
   always @(posedge mclk) begin
      if (rst) begin
         tick_r <= 32'h00000000;
         scanCur_r <= 16'h0000;
         scanSeen_r <= 1'b0;
         maxScanTimeWord <= 16'h0000;
      end else if (scanStart) begin
         if (scanSeen_r && scanFinal > maxScanTimeWord) begin
            maxScanTimeWord <= scanFinal;
         end
         scanSeen_r <= 1'b1;
         tick_r <= 32'h00000000;
         scanCur_r <= 16'h0000;
      end else if (stepDue) begin
         tick_r <= 32'h00000000;
         if (scanCur_r != 16'hFFFF) begin
            scanCur_r <= scanCur_r + 16'h0001;
         end
      end else begin
         tick_r <= tick_r + 32'h00000001;
      end
   end
endmodule
`default_nettype wire

// *** src/word_writer.v ***
// Word memory with a registered read port, used as the built-in RAM store.
// Assumes one clock; writes and reads are single cycle.
`timescale 1ns/100ps
`default_nettype none
module word_writer #(
   parameter AW = 15,
   parameter DW = 16
) (
   input  wire          mclk,
   input  wire          wrEn,
   input  wire [AW-1:0] wrAddr,
   input  wire [DW-1:0] wrData,
   input  wire [AW-1:0] rdAddr,
   output reg  [DW-1:0] rdData
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge mclk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule
`default_nettype wire

// *** tb/flash_cassette.sv ***
// Behavioural flash cassette: counts erased-value words written to it.
// Assumes writes arrive one word per mclk cycle on the write strobe.
`timescale 1ns/100ps
`default_nettype none
module flash_cassette (
   input  wire logic        mclk,
   input  wire logic        clr,
   input  wire logic        wrEn,
   input  wire logic [14:0] wrAddr,
   input  wire logic [15:0] wrData,
   output var  logic [15:0] writes,
   output var  logic [14:0] lastAddr
);
   // A word with any other value is not counted, so bad data shows as a
   // short count.
   always @(posedge mclk) begin
      if (clr) begin
         writes <= 16'h0000;
         lastAddr <= 15'h0000;
      end else if (wrEn === 1'b1 && wrData === 16'hFFFF) begin
         writes <= writes + 16'h0001;
         lastAddr <= wrAddr;
      end
   end
endmodule
`default_nettype wire

// *** tb/sector_clear_checker.sv ***
// Checker for the sector clear engine's cassette port and status outputs.
// Assumes it is bound to sector_clear and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module sector_clear_checker (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        busy,
   input wire logic        execDone,
   input wire logic        flashWrEn,
   input wire logic [14:0] flashWrAddr,
   input wire logic [15:0] flashWrData,
   input wire logic        operationErrorFlag,
   input wire logic [15:0] operationErrorCode
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ==========================================================
   // Assertions
   erased_data_a: assert property (
      flashWrEn |-> flashWrData == 16'hFFFF) else $error("bad word");
   word_step_a: assert property (
      flashWrEn && $past(flashWrEn) |-> flashWrAddr == $past(flashWrAddr)
      + 15'h0001) else $error("address not consecutive");
   sector_head_a: assert property (
      $rose(flashWrEn) |-> flashWrAddr[10:0] == 11'h000)
      else $error("run not at sector head");
   write_busy_a: assert property (
      flashWrEn |-> busy) else $error("write while idle");
   done_fall_a: assert property (
      $fell(busy) |-> execDone) else $error("no done at end");
   done_pulse_a: assert property (
      execDone |=> !execDone) else $error("done too long");
   err_code_a: assert property (
      operationErrorFlag |-> operationErrorCode inside {16'h1A32, 16'h1A72})
      else $error("bad error code");
   err_sticky_a: assert property (
      operationErrorFlag |=> operationErrorFlag) else $error("flag dropped");
   busy_c: cover property ($rose(busy));
   err_c: cover property ($rose(operationErrorFlag));
   write_c: cover property ($rose(flashWrEn));
   done_c: cover property ($fell(busy));
endmodule
bind sector_clear sector_clear_checker u_chk (.mclk(mclk), .rst(rst),
   .busy(busy), .execDone(execDone), .flashWrEn(flashWrEn),
   .flashWrAddr(flashWrAddr), .flashWrData(flashWrData),
   .operationErrorFlag(operationErrorFlag),
   .operationErrorCode(operationErrorCode));
`default_nettype wire

// *** tb/sector_clear_tb_top.sv ***
// Testbench for sector_clear with shortened sector times.
// Assumes a flash_cassette model on the write port.
`timescale 1ns/100ps
`default_nettype none
module sector_clear_tb_top;
   logic mclk = 0, rst = 1, enable = 0, cas = 0, prot = 0, clr = 1;
   logic single = 1, scanStart = 0;
   logic [14:0] startWord = 0, ramRdAddr = 0;
   logic [4:0]  sectorCount = 1;
   wire logic [15:0] ramRdData, flashWrData, code, wcount, writes, maxScan;
   wire logic [14:0] flashWrAddr, lastAddr;
   wire logic        flashWrEn, busy, execDone, errFlag, limit;
   integer mismatches = 0, samples_checked = 0;
   always #5 mclk = ~mclk;
   sector_clear #(.FLASH_SECTOR_CYC(2200), .RAM_SECTOR_CYC(2100),
      .SCAN_TICK_CYC(10)) i_dut (.mclk(mclk), .rst(rst), .enable(enable),
      .singleShot(single), .startWord(startWord), .sectorCount(sectorCount),
      .cassettePresent(cas), .protectSwitch(prot), .scanStart(scanStart),
      .ramRdAddr(ramRdAddr), .ramRdData(ramRdData), .flashWrEn(flashWrEn),
      .flashWrAddr(flashWrAddr), .flashWrData(flashWrData), .busy(busy),
      .execDone(execDone), .operationErrorFlag(errFlag),
      .operationErrorCode(code), .maxScanTimeWord(maxScan),
      .flashWriteCount(wcount), .writeLimitReached(limit));
   flash_cassette i_cas (.mclk(mclk), .clr(clr), .wrEn(flashWrEn),
      .wrAddr(flashWrAddr), .wrData(flashWrData), .writes(writes),
      .lastAddr(lastAddr));
   // ==========================================================
   // Checking and reporting
   task close_out;
      begin
         $display("mismatches=%0d samples_checked=%0d", mismatches,
            samples_checked);
         if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Words outside every cleared range were never written, so they
   // still read unknown; that catches a run that starts or ends astray.
   task rd(input logic [14:0] a, input logic [15:0] e);
      begin
         ramRdAddr = a;
         repeat (3) @(posedge mclk);
         #1 cmp(ramRdData, e);
      end
   endtask
   task pulse_scan;
      begin
         scanStart = 1;
         @(posedge mclk);
         #1 scanStart = 0;
      end
   endtask
   // Busy cycles are counted to judge the per-sector pacing.
   task op(input logic [14:0] s, input logic [4:0] n, input logic c,
      input logic p, input logic [15:0] w, input logic [15:0] e,
      input integer lo, input integer hi);
      integer i, b;
      begin
         startWord = s;
         sectorCount = n;
         cas = c;
         prot = p;
         clr = 1;
         repeat (3) @(posedge mclk);
         #1 clr = 0;
         // The wait bound is the bench's watchdog: sized above the longest
         // clear asked for, and restarted just as the command is raised.
         enable = 1;
         b = 0;
         for (i = 0; i < 20000 && execDone !== 1'b1; i = i + 1) begin
            @(posedge mclk);
            #1 if (busy === 1'b1) b = b + 1;
         end
         enable = 0;
         if (i == 20000) begin
            mismatches = mismatches + 1;
            close_out;
         end
         cmp(writes, w);
         cmp(code, e);
         cmp({15'h0, b >= lo && b <= hi}, 16'h0001);
      end
   endtask
   // ==========================================================
   // Scenarios
   task t_flash;
      begin
         op(15'h0800, 5'h02, 1, 0, 16'h1000, 16'h0000, 4392, 4408);
         rd(15'h0800, 16'hFFFF);
         rd(15'h17FF, 16'hFFFF);
         rd(15'h1800, 16'hXXXX);
         rd(15'h07FF, 16'hXXXX);
         cmp({1'b0, lastAddr}, 16'h17FF);
         cmp(wcount, 16'h0001);
      end
   endtask
   task t_ram;
      begin
         op(15'h0000, 5'h01, 0, 0, 16'h0000, 16'h0000, 2096, 2104);
         rd(15'h07FF, 16'hFFFF);
         cmp(wcount, 16'h0001);
      end
   endtask
   task t_overflow;
      begin
         op(15'h7800, 5'h02, 1, 0, 16'h0800, 16'h1A32, 2192, 2208);
         rd(15'h7800, 16'hFFFF);
         rd(15'h7FFF, 16'hFFFF);
         cmp({1'b0, lastAddr}, 16'h7FFF);
      end
   endtask
   // Continuous form: the clear repeats while enabled, and every
   // execution spends one flash write cycle.
   task t_repeat;
      integer i, d;
      logic [15:0] w0;
      begin
         w0 = wcount;
         single = 0;
         startWord = 15'h2000;
         sectorCount = 5'h01;
         cas = 1;
         prot = 0;
         clr = 1;
         repeat (3) @(posedge mclk);
         #1 clr = 0;
         enable = 1;
         d = 0;
         for (i = 0; i < 20000 && d < 2; i = i + 1) begin
            @(posedge mclk);
            #1 if (execDone === 1'b1) d = d + 1;
         end
         enable = 0;
         single = 1;
         if (d < 2) begin
            mismatches = mismatches + 1;
            close_out;
         end
         cmp(writes, 16'h1000);
         cmp({1'b0, lastAddr}, 16'h27FF);
         cmp(wcount, w0 + 16'h0002);
         cmp({15'h0, limit}, 16'h0000);
      end
   endtask
   // Scan time unit is 10 clocks here, so a 100-clock scan reads 10.
   task t_scan;
      begin
         pulse_scan;
         repeat (99) @(posedge mclk);
         #1 pulse_scan;
         cmp(maxScan, 16'h000A);
         repeat (54) @(posedge mclk);
         #1 pulse_scan;
         cmp(maxScan, 16'h000A);
         repeat (149) @(posedge mclk);
         #1 pulse_scan;
         cmp(maxScan, 16'h000F);
      end
   endtask
   task t_refuse;
      begin
         op(15'h0000, 5'h01, 1, 1, 16'h0000, 16'h1A72, 0, 0);
         op(15'h0801, 5'h01, 1, 0, 16'h0000, 16'h1A32, 0, 0);
         cmp({15'h0, errFlag}, 16'h0001);
      end
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      #1 rst = 0;
      t_flash;
      t_ram;
      t_overflow;
      t_refuse;
      t_repeat;
      t_scan;
      close_out;
   end
endmodule
`default_nettype wire
